// file: design/tas_selector.sv
// Purpose: Tariff selector steering energy/volume increments to accumulators
// Assumes: Increment pulses and measured values come from sys_clk logic
// Notes:   Enables are one-cycle pulses one edge after each increment
//
// Notes on behaviour
// - Difference band two to third: second accumulator
// - Difference band three to fourth: third accumulator
// - Below fourth: fourth; at/above second: main
// - Inlet temperature ascending bands, upper bounds inclusive
// - Outlet temperature uses same ascending bands
// - Time windows second/third feed second/third accumulators
// - Fourth time round midnight feeds fourth
// - Volume mode: every volume increment counts total
// - Heat flow at/above changeover adds second accumulator
// - Cooling flow at/below changeover adds third accumulator
// - Equal temperatures count total volume only
// - Volume mode works only for heat/cooling meters
// - Volume mode ignores limits, fourth accumulator unused
// - Power over second, flow over third limit
// - Both over limits feed both accumulators
// - Power/flow mode never uses fourth accumulator
// - No-tariff code leaves only the main register and total volume
//
// The AXI4-Lite register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module tas_selector
  import tas_pkg::*;
(
  input  wire logic                sys_clk,
  input  wire logic                sys_rst,
  // AXI4-Lite slave
  input  wire logic [ADDR_W-1:0]   awaddr,
  input  wire logic                awvalid,
  output logic                     awready,
  input  wire logic [DATA_W-1:0]   wdata,
  input  wire logic [3:0]          wstrb,
  input  wire logic                wvalid,
  output logic                     wready,
  output logic [1:0]               bresp,
  output logic                     bvalid,
  input  wire logic                bready,
  input  wire logic [ADDR_W-1:0]   araddr,
  input  wire logic                arvalid,
  output logic                     arready,
  output logic [DATA_W-1:0]        rdata,
  output logic [1:0]               rresp,
  output logic                     rvalid,
  input  wire logic                rready,
  // Metering side
  input  wire logic                energyIncIn,
  input  wire logic                volumeIncIn,
  input  wire tas_meas_t           measIn,
  output tas_route_t               routeOut
);
  // Bus state
  logic [ADDR_W-1:0] awAddr_ff;     // Held write address
  logic              awHeld_ff;     // Write address taken
  logic [DATA_W-1:0] wData_ff;      // Held write data
  logic [3:0]        wStrb_ff;      // Held byte strobes
  logic              wHeld_ff;      // Write data taken
  logic              doWrite;       // Both halves present, no response out
  logic              wrHit;         // Write address maps to a register
  logic [31:0]       wrOld;         // Addressed register before the write
  logic [31:0]       wrMerged;      // Its value with the strobed bytes in
  // Configuration and status
  logic [7:0]        tariffTypeCode_ff;
  logic [3:0]        meterType_ff;
  logic [15:0]       limitSecond_ff;
  logic [15:0]       limitThird_ff;
  logic [15:0]       limitFourth_ff;
  logic [15:0]       changeover_ff; // Heat/cooling changeover threshold
  logic [31:0]       incCount_ff;   // Cycles with an energy or volume increment so far
  // Selection
  tas_route_t        nxt_route;
  logic signed [16:0] diffTemp;     // Inlet minus outlet
  logic signed [16:0] bandValue;    // Value fed to the band classifier
  logic              bandDesc;
  logic [2:0]        bandHit;
  logic [2:0]        windowHit;
  logic              hcMeter;
  logic              heatCase;
  logic              coolCase;
  logic [DATA_W-1:0] rdMux;
  logic              rdHit;

  // Byte-lane merge for 16-bit and 32-bit register writes
  function automatic logic [31:0] mergeBytes(input logic [31:0] oldV,
                                             input logic [31:0] newV,
                                             input logic [3:0]  strb);
    for (int b = 0; b < 4; b++) begin
      mergeBytes[8*b +: 8] = strb[b] ? newV[8*b +: 8] : oldV[8*b +: 8];
    end
  endfunction

  assign doWrite = awHeld_ff && wHeld_ff && !bvalid;
  assign wrHit   = (awAddr_ff == OFF_CTRL) || (awAddr_ff == OFF_LIM2) ||
                   (awAddr_ff == OFF_LIM3) || (awAddr_ff == OFF_LIM4) ||
                   (awAddr_ff == OFF_THR);

  // Write address channel: take once, reopen after the response
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      awAddr_ff <= '0;
      awHeld_ff <= 1'b0;
      awready   <= 1'b1;
    end else if (awvalid && awready) begin
      awAddr_ff <= awaddr;
      awHeld_ff <= 1'b1;
      awready   <= 1'b0;
    end else begin
      if (doWrite) begin
        awHeld_ff <= 1'b0;
      end
      if (bvalid && bready) begin
        awready <= 1'b1;
      end
    end
  end

  // Write data channel: independent of the address channel
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      wData_ff <= '0;
      wStrb_ff <= '0;
      wHeld_ff <= 1'b0;
      wready   <= 1'b1;
    end else if (wvalid && wready) begin
      wData_ff <= wdata;
      wStrb_ff <= wstrb;
      wHeld_ff <= 1'b1;
      wready   <= 1'b0;
    end else begin
      if (doWrite) begin
        wHeld_ff <= 1'b0;
      end
      if (bvalid && bready) begin
        wready <= 1'b1;
      end
    end
  end

  // Write response; unmapped offsets answer SLVERR
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      bvalid <= 1'b0;
      bresp  <= RESP_OKAY;
    end else if (doWrite) begin
      bvalid <= 1'b1;
      bresp  <= wrHit ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid && bready) begin
      bvalid <= 1'b0;
    end
  end

  // Addressed register with the strobed bytes of the held data merged in
  always_comb begin
    case (awAddr_ff)
      OFF_CTRL: wrOld = {20'h00000, meterType_ff, tariffTypeCode_ff};
      OFF_LIM2: wrOld = {16'h0000, limitSecond_ff};
      OFF_LIM3: wrOld = {16'h0000, limitThird_ff};
      OFF_LIM4: wrOld = {16'h0000, limitFourth_ff};
      OFF_THR:  wrOld = {16'h0000, changeover_ff};
      default:  wrOld = '0;
    endcase
    wrMerged = mergeBytes(wrOld, wData_ff, wStrb_ff);
  end

  // Configuration registers, written with byte strobes
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      tariffTypeCode_ff <= RST_CODE;
      meterType_ff      <= RST_MTYPE;
      limitSecond_ff    <= RST_LIM;
      limitThird_ff     <= RST_LIM;
      limitFourth_ff    <= RST_LIM;
      changeover_ff     <= RST_LIM;
    end else if (doWrite) begin
      case (awAddr_ff)
        OFF_CTRL: begin
          tariffTypeCode_ff <= wrMerged[CTRL_CODE_MSB:CTRL_CODE_LSB];
          meterType_ff      <= wrMerged[CTRL_MTYPE_MSB:CTRL_MTYPE_LSB];
        end
        OFF_LIM2: limitSecond_ff <= wrMerged[15:0];
        OFF_LIM3: limitThird_ff  <= wrMerged[15:0];
        OFF_LIM4: limitFourth_ff <= wrMerged[15:0];
        OFF_THR:  changeover_ff  <= wrMerged[15:0];
        default: begin
          // Unmapped: nothing stored
        end
      endcase
    end
  end

  // Read data selection; reserved bits read zero
  always_comb begin
    rdHit = 1'b1;
    rdMux = '0;
    case (araddr)
      OFF_CTRL: rdMux = {20'h00000, meterType_ff, tariffTypeCode_ff};
      OFF_LIM2: rdMux = {16'h0000, limitSecond_ff};
      OFF_LIM3: rdMux = {16'h0000, limitThird_ff};
      OFF_LIM4: rdMux = {16'h0000, limitFourth_ff};
      OFF_THR:  rdMux = {16'h0000, changeover_ff};
      OFF_STAT: rdMux = {27'h0000000, routeOut};
      OFF_CNT:  rdMux = incCount_ff;
      default:  rdHit = 1'b0;
    endcase
  end

  // Read channel: one read under way, answer one edge after address
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= '0;
      rresp   <= RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rdata   <= rdMux;
      rresp   <= rdHit ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end
  end

  // Measured quantity for the band classifier
  assign diffTemp  = 17'(measIn.inletTemp) - 17'(measIn.outletTemp);
  assign bandDesc  = (tariffTypeCode_ff == CODE_DT);
  always_comb begin
    case (tariffTypeCode_ff)
      CODE_DT:     bandValue = diffTemp;
      CODE_INLET:  bandValue = 17'(measIn.inletTemp);
      CODE_OUTLET: bandValue = 17'(measIn.outletTemp);
      default:     bandValue = '0;
    endcase
  end

  tas_band_sel u_band (
    .value      (bandValue),
    .limSecond  (17'($signed(limitSecond_ff))),
    .limThird   (17'($signed(limitThird_ff))),
    .limFourth  (17'($signed(limitFourth_ff))),
    .descending (bandDesc),
    .bandHit    (bandHit)
  );

  tas_time_sel u_time (
    .timeOfDay (measIn.timeOfDay),
    .limSecond (limitSecond_ff),
    .limThird  (limitThird_ff),
    .limFourth (limitFourth_ff),
    .windowHit (windowHit)
  );

  // Heat/cooling split conditions
  assign hcMeter  = (meterType_ff == MTYPE_HC_A) ||
                    (meterType_ff == MTYPE_HC_B);
  assign heatCase = (measIn.inletTemp > measIn.outletTemp) &&
                    (measIn.inletTemp >= $signed(changeover_ff));
  assign coolCase = !heatCase &&
                    (measIn.outletTemp > measIn.inletTemp) &&
                    (measIn.inletTemp <= $signed(changeover_ff));

  // Route each increment from values current in its own cycle
  always_comb begin
    nxt_route             = '0;
    nxt_route.mainReg     = energyIncIn;
    nxt_route.totalVolume = volumeIncIn;
    case (tariffTypeCode_ff)
      CODE_DT, CODE_INLET, CODE_OUTLET: begin
        if (energyIncIn) begin
          nxt_route.accumSecond = bandHit[0];
          nxt_route.accumThird  = bandHit[1];
          nxt_route.accumFourth = bandHit[2];
        end
      end
      CODE_TIME: begin
        if (energyIncIn) begin
          nxt_route.accumSecond = windowHit[0];
          nxt_route.accumThird  = windowHit[1];
          nxt_route.accumFourth = windowHit[2];
        end
      end
      CODE_HCVOL: begin
        // Limits ignored, fourth accumulator stays idle
        if (volumeIncIn && hcMeter) begin
          nxt_route.accumSecond = heatCase;
          nxt_route.accumThird  = coolCase;
        end
      end
      CODE_PQ: begin
        if (energyIncIn) begin
          nxt_route.accumSecond =
            measIn.power > $signed(limitSecond_ff);
          nxt_route.accumThird  =
            measIn.flow > $signed(limitThird_ff);
        end
      end
      default: begin
        // No tariff, or unused code: main register and total volume only
      end
    endcase
  end

  // Registered accumulator enables
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      routeOut <= '0;
    end else begin
      routeOut <= nxt_route;
    end
  end

  // Increment counter for software
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      incCount_ff <= '0;
    end else if (energyIncIn || volumeIncIn) begin
      incCount_ff <= incCount_ff + 32'h00000001;
    end
  end

  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  sequence s_dtEnergy;
    energyIncIn && tariffTypeCode_ff == CODE_DT;
  endsequence
  sequence s_hcVol;
    volumeIncIn && tariffTypeCode_ff == CODE_HCVOL && hcMeter;
  endsequence

  property p_dt_second;
    s_dtEnergy ##0 (diffTemp < $signed(limitSecond_ff) &&
      diffTemp >= $signed(limitThird_ff) &&
      limitThird_ff != limitSecond_ff) |=> routeOut.accumSecond;
  endproperty
  a_dt_second: assert property (p_dt_second)
    else $error("difference band two not routed");

  property p_dt_third;
    s_dtEnergy ##0 (diffTemp < $signed(limitThird_ff) &&
      diffTemp >= $signed(limitFourth_ff)) |=>
      routeOut.accumThird && !routeOut.accumFourth;
  endproperty
  a_dt_third: assert property (p_dt_third)
    else $error("difference band three not routed");

  property p_dt_main_only;
    s_dtEnergy ##0 (diffTemp >= $signed(limitSecond_ff)) |=>
      routeOut.mainReg && routeOut[3:1] == 3'h0;
  endproperty
  a_dt_main_only: assert property (p_dt_main_only)
    else $error("difference above top limit hit an accumulator");

  property p_inlet_top;
    energyIncIn && tariffTypeCode_ff == CODE_INLET &&
      measIn.inletTemp > $signed(limitFourth_ff) |=>
      routeOut.accumFourth && !routeOut.accumSecond;
  endproperty
  a_inlet_top: assert property (p_inlet_top)
    else $error("inlet above fourth limit not in fourth");

  property p_outlet_low;
    energyIncIn && tariffTypeCode_ff == CODE_OUTLET &&
      measIn.outletTemp <= $signed(limitSecond_ff) |=>
      routeOut[3:1] == 3'h0;
  endproperty
  a_outlet_low: assert property (p_outlet_low)
    else $error("outlet at or below second limit counted");

  property p_time_night;
    energyIncIn && tariffTypeCode_ff == CODE_TIME &&
      limitSecond_ff < limitThird_ff && limitThird_ff < limitFourth_ff &&
      measIn.timeOfDay >= limitFourth_ff |=> routeOut.accumFourth;
  endproperty
  a_time_night: assert property (p_time_night)
    else $error("late time not in fourth accumulator");

  property p_hc_split;
    s_hcVol |=> routeOut.totalVolume && !routeOut.accumFourth &&
      routeOut.accumSecond == $past(heatCase) &&
      routeOut.accumThird == $past(coolCase);
  endproperty
  a_hc_split: assert property (p_hc_split)
    else $error("heat/cooling volume split wrong");

  property p_hc_equal;
    s_hcVol ##0 (measIn.inletTemp == measIn.outletTemp) |=>
      routeOut.totalVolume && !routeOut.accumSecond &&
      !routeOut.accumThird;
  endproperty
  a_hc_equal: assert property (p_hc_equal)
    else $error("equal temperatures counted in accumulator");

  property p_hc_meter;
    volumeIncIn && !energyIncIn && !hcMeter |=> routeOut[3:1] == 3'h0;
  endproperty
  a_hc_meter: assert property (p_hc_meter)
    else $error("volume split on wrong meter type");

  property p_pq_both;
    energyIncIn && tariffTypeCode_ff == CODE_PQ &&
      measIn.power > $signed(limitSecond_ff) &&
      measIn.flow > $signed(limitThird_ff) |=>
      routeOut.accumSecond && routeOut.accumThird &&
      routeOut.mainReg && !routeOut.accumFourth;
  endproperty
  a_pq_both: assert property (p_pq_both)
    else $error("power and flow over limits not both routed");

  property p_none;
    tariffTypeCode_ff == CODE_NONE |=> routeOut[3:1] == 3'h0;
  endproperty
  a_none: assert property (p_none)
    else $error("accumulator enabled with no tariff");

  property p_idle;
    !energyIncIn && !volumeIncIn |=> routeOut == '0;
  endproperty
  a_idle: assert property (p_idle)
    else $error("enable without an increment");
endmodule

// file: design/tas_pkg.sv
// Purpose: Shared constants and carriers of the tariff accumulation selector
// Assumes: 32-bit AXI4-Lite register bus, 16-bit measured values
// Notes:   Tariff codes are the decimal codes held as binary values
package tas_pkg;
  // Bus widths
  localparam int          DATA_W          = 32;
  localparam int          ADDR_W          = 8;
  // Tariff type codes
  localparam logic [7:0]  CODE_NONE       = 8'h00;
  localparam logic [7:0]  CODE_DT         = 8'h0D;
  localparam logic [7:0]  CODE_INLET      = 8'h0E;
  localparam logic [7:0]  CODE_OUTLET     = 8'h0F;
  localparam logic [7:0]  CODE_TIME       = 8'h13;
  localparam logic [7:0]  CODE_HCVOL      = 8'h14;
  localparam logic [7:0]  CODE_PQ         = 8'h15;
  // Combined heat/cooling meter types
  localparam logic [3:0]  MTYPE_HC_A      = 4'h3;
  localparam logic [3:0]  MTYPE_HC_B      = 4'h6;
  // Register byte offsets
  localparam logic [7:0]  OFF_CTRL        = 8'h00;
  localparam logic [7:0]  OFF_LIM2        = 8'h04;
  localparam logic [7:0]  OFF_LIM3        = 8'h08;
  localparam logic [7:0]  OFF_LIM4        = 8'h0C;
  localparam logic [7:0]  OFF_THR         = 8'h10;
  localparam logic [7:0]  OFF_STAT        = 8'h14;
  localparam logic [7:0]  OFF_CNT         = 8'h18;
  // Control register fields
  localparam int          CTRL_CODE_LSB   = 0;
  localparam int          CTRL_CODE_MSB   = 7;
  localparam int          CTRL_MTYPE_LSB  = 8;
  localparam int          CTRL_MTYPE_MSB  = 11;
  // Reset values
  localparam logic [7:0]  RST_CODE        = 8'h00;
  localparam logic [3:0]  RST_MTYPE       = 4'h0;
  localparam logic [15:0] RST_LIM         = 16'h0000;
  // Bus responses
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;

  // Measured values, current at each increment
  typedef struct packed {
    logic signed [15:0] inletTemp;
    logic signed [15:0] outletTemp;
    logic signed [15:0] power;
    logic signed [15:0] flow;
    logic [15:0]        timeOfDay;
  } tas_meas_t;

  // Accumulator enables
  typedef struct packed {
    logic totalVolume;
    logic accumFourth;
    logic accumThird;
    logic accumSecond;
    logic mainReg;
  } tas_route_t;
endpackage

// file: design/tas_band_sel.sv
// Purpose: Three-band limit classifier, ascending or descending
// Assumes: Limits programmed in the order the chosen direction needs
// Notes:   Purely combinational; bit 0 is the second accumulator band
`timescale 1ns/1ps
module tas_band_sel
  import tas_pkg::*;
(
  input  wire logic signed [16:0] value,
  input  wire logic signed [16:0] limSecond,
  input  wire logic signed [16:0] limThird,
  input  wire logic signed [16:0] limFourth,
  input  wire logic               descending,
  output logic [2:0]              bandHit
);
  // Band edges in order second, third, fourth
  logic signed [16:0] bound [0:2];

  assign bound[0] = limSecond;
  assign bound[1] = limThird;
  assign bound[2] = limFourth;

  // One band per accumulator; the last band is open-ended
  genvar gi;
  for (gi = 0; gi < 3; gi++) begin : g_band
    if (gi < 2) begin : g_mid
      assign bandHit[gi] = descending ?
        (value < bound[gi] && value >= bound[gi+1]) :
        (value > bound[gi] && value <= bound[gi+1]);
    end else begin : g_top
      assign bandHit[gi] = descending ? (value < bound[gi]) :
                                        (value > bound[gi]);
    end
  end
endmodule

// file: design/tas_time_sel.sv
// Purpose: Time-of-day window classifier for the time tariff
// Assumes: Times given as minutes of the day, same unit for all inputs
// Notes:   Windows include their start and exclude their end
`timescale 1ns/1ps
module tas_time_sel
  import tas_pkg::*;
(
  input  wire logic [15:0] timeOfDay,
  input  wire logic [15:0] limSecond,
  input  wire logic [15:0] limThird,
  input  wire logic [15:0] limFourth,
  output logic [2:0]       windowHit
);
  // Window test that also handles a window wrapping past midnight
  function automatic logic inWindow(input logic [15:0] startT,
                                    input logic [15:0] endT,
                                    input logic [15:0] nowT);
    if (startT <= endT) begin
      inWindow = (nowT >= startT) && (nowT < endT);
    end else begin
      inWindow = (nowT >= startT) || (nowT < endT);
    end
  endfunction

  // Second, third, then fourth window back round to the second start
  assign windowHit[0] = inWindow(limSecond, limThird, timeOfDay);
  assign windowHit[1] = inWindow(limThird, limFourth, timeOfDay);
  assign windowHit[2] = inWindow(limFourth, limSecond, timeOfDay);
endmodule

// file: testbench/tas_selector_tb.sv
// Purpose: Self-checking bench for the tariff selector
// Assumes: Bus and routing answers come well inside the timeout
// Notes:   Each increment is checked one edge after its pulse
`timescale 1ns/1ps
module tas_selector_tb
  import tas_pkg::*;
;
  logic              sys_clk = 1'b0;   // 10 MHz clock
  logic              sys_rst = 1'b1;   // Synchronous reset
  logic [ADDR_W-1:0] awaddr, araddr;   // Bus addresses
  logic [DATA_W-1:0] wdata, rdata;     // Bus data
  logic [3:0]        wstrb;            // Byte lanes
  logic [1:0]        bresp, rresp;     // Responses
  logic              awvalid, awready, wvalid, wready, bvalid, bready;
  logic              arvalid, arready, rvalid, rready;
  logic              energyIncIn, volumeIncIn;
  tas_meas_t         measIn;           // Measured values
  tas_route_t        routeOut;         // Accumulator enables
  int                err_total, comparisons, cyc;
  logic [15:0]       tv [6] = '{16'h28, 16'h29, 16'h3C, 16'h3D, 16'h50, 16'h51};
  logic [4:0]        te [6] = '{5'h01, 5'h03, 5'h03, 5'h05, 5'h05, 5'h09};

  tas_selector dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .energyIncIn(energyIncIn), .volumeIncIn(volumeIncIn), .measIn(measIn),
    .routeOut(routeOut));

  // Clock generator
  always #50 sys_clk = ~sys_clk;

  // Hang guard
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_total++;
      finish_test();
    end
  end

  // Compare and count
  task check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Verdict
  task finish_test();
    $display("Counts: %0d compares, %0d mismatches", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Bus write; each channel released once taken
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ta, tw, tb;
    logic [1:0] r;
    @(posedge sys_clk);
    awaddr <= a; wdata <= d; wstrb <= 4'hF;
    awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    @(negedge sys_clk);
    while (awvalid || wvalid || bready) begin
      ta = awvalid && awready; tw = wvalid && wready; tb = bvalid; r = bresp;
      @(posedge sys_clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tb) begin
        bready <= 1'b0;
        check(32'(r), 32'(er));
      end
      @(negedge sys_clk);
    end
  endtask

  // Bus read with data and response compare
  task rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic ta, tr;
    logic [31:0] d;
    logic [1:0] r;
    @(posedge sys_clk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    @(negedge sys_clk);
    while (arvalid || rready) begin
      ta = arvalid && arready; tr = rvalid; d = rdata; r = rresp;
      @(posedge sys_clk);
      if (ta) arvalid <= 1'b0;
      if (tr) begin
        rready <= 1'b0;
        check(d, ed);
        check(32'(r), 32'(er));
      end
      @(negedge sys_clk);
    end
  endtask

  // Setup: code, meter type, three limits, changeover threshold
  task cfg(input logic [7:0] c, input logic [3:0] mt,
           input logic [15:0] l2, l3, l4, th);
    wr(OFF_CTRL, {20'h0, mt, c}, RESP_OKAY);
    wr(OFF_LIM2, {16'h0, l2}, RESP_OKAY);
    wr(OFF_LIM3, {16'h0, l3}, RESP_OKAY);
    wr(OFF_LIM4, {16'h0, l4}, RESP_OKAY);
    wr(OFF_THR, {16'h0, th}, RESP_OKAY);
  endtask

  // One increment; route must pulse for exactly one cycle
  task inc(input logic e, input logic v, input logic [15:0] ti, to, p, q,
           input logic [15:0] tod, input logic [4:0] ex);
    @(posedge sys_clk);
    energyIncIn <= e; volumeIncIn <= v; measIn <= {ti, to, p, q, tod};
    @(posedge sys_clk);
    energyIncIn <= 1'b0; volumeIncIn <= 1'b0;
    @(negedge sys_clk);
    check(32'(routeOut), 32'(ex));
    @(negedge sys_clk);
    check(32'(routeOut), 32'h0);
  endtask

  initial begin
    awaddr = 8'h0; araddr = 8'h0; wdata = 32'h0; wstrb = 4'h0;
    awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0;
    rready = 1'b0; energyIncIn = 1'b0; volumeIncIn = 1'b0;
    measIn = '0; err_total = 0; comparisons = 0; cyc = 0;
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    rd(OFF_CTRL, 32'h0, RESP_OKAY);
    rd(OFF_LIM4, 32'h0, RESP_OKAY);
    rd(8'h1C, 32'h0, RESP_SLVERR);
    wr(OFF_STAT, 32'h1, RESP_SLVERR);
    inc(1'b1, 1'b0, 16'h64, 16'h0, 16'h0, 16'h0, 16'h0, 5'h01);
    $display("Test registers and no tariff done");
    cfg(CODE_DT, 4'h0, 16'h14, 16'h0A, 16'h05, 16'h0);
    inc(1'b1, 1'b0, 16'h24, 16'h10, 16'h0, 16'h0, 16'h0, 5'h01);
    inc(1'b1, 1'b0, 16'h23, 16'h10, 16'h0, 16'h0, 16'h0, 5'h03);
    inc(1'b1, 1'b0, 16'h1A, 16'h10, 16'h0, 16'h0, 16'h0, 5'h03);
    inc(1'b1, 1'b0, 16'h19, 16'h10, 16'h0, 16'h0, 16'h0, 5'h05);
    inc(1'b1, 1'b0, 16'h15, 16'h10, 16'h0, 16'h0, 16'h0, 5'h05);
    inc(1'b1, 1'b0, 16'h14, 16'h10, 16'h0, 16'h0, 16'h0, 5'h09);
    inc(1'b1, 1'b0, 16'h0E, 16'h10, 16'h0, 16'h0, 16'h0, 5'h09);
    $display("Test difference tariff done");
    cfg(CODE_INLET, 4'h0, 16'h28, 16'h3C, 16'h50, 16'h0);
    for (int i = 0; i < 6; i++)
      inc(1'b1, 1'b0, tv[i], 16'h0, 16'h0, 16'h0, 16'h0, te[i]);
    inc(1'b1, 1'b0, 16'hFFF6, 16'h0, 16'h0, 16'h0, 16'h0, 5'h01);
    wr(OFF_CTRL, {24'h0, CODE_OUTLET}, RESP_OKAY);
    for (int i = 0; i < 6; i++)
      inc(1'b1, 1'b0, 16'h0, tv[i], 16'h0, 16'h0, 16'h0, te[i]);
    $display("Test temperature tariffs done");
    cfg(CODE_TIME, 4'h0, 16'h1E0, 16'h3C0, 16'h564, 16'h0);
    inc(1'b1, 1'b0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h1DF, 5'h09);
    inc(1'b1, 1'b0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h1E0, 5'h03);
    inc(1'b1, 1'b0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h3BF, 5'h03);
    inc(1'b1, 1'b0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h3C0, 5'h05);
    inc(1'b1, 1'b0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h563, 5'h05);
    inc(1'b1, 1'b0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h564, 5'h09);
    inc(1'b1, 1'b0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 5'h09);
    $display("Test time tariff done");
    cfg(CODE_HCVOL, MTYPE_HC_A, 16'h7, 16'h5, 16'h1, 16'h19);
    rd(OFF_CTRL, {20'h0, MTYPE_HC_A, CODE_HCVOL}, RESP_OKAY);
    rd(OFF_THR, 32'h19, RESP_OKAY);
    inc(1'b0, 1'b1, 16'h1E, 16'h14, 16'h0, 16'h0, 16'h0, 5'h12);
    inc(1'b0, 1'b1, 16'h19, 16'h14, 16'h0, 16'h0, 16'h0, 5'h12);
    inc(1'b0, 1'b1, 16'h14, 16'h0A, 16'h0, 16'h0, 16'h0, 5'h10);
    inc(1'b0, 1'b1, 16'h14, 16'h1E, 16'h0, 16'h0, 16'h0, 5'h14);
    inc(1'b0, 1'b1, 16'h1E, 16'h28, 16'h0, 16'h0, 16'h0, 5'h10);
    inc(1'b0, 1'b1, 16'h14, 16'h14, 16'h0, 16'h0, 16'h0, 5'h10);
    inc(1'b1, 1'b0, 16'h1E, 16'h14, 16'h0, 16'h0, 16'h0, 5'h01);
    wr(OFF_CTRL, {20'h0, MTYPE_HC_B, CODE_HCVOL}, RESP_OKAY);
    inc(1'b0, 1'b1, 16'h1E, 16'h14, 16'h0, 16'h0, 16'h0, 5'h12);
    wr(OFF_CTRL, {20'h0, 4'h4, CODE_HCVOL}, RESP_OKAY);
    inc(1'b0, 1'b1, 16'h1E, 16'h14, 16'h0, 16'h0, 16'h0, 5'h10);
    $display("Test volume tariff done");
    cfg(CODE_PQ, 4'h0, 16'h64, 16'h32, 16'h0, 16'h0);
    inc(1'b1, 1'b0, 16'h0, 16'h0, 16'h64, 16'h32, 16'h0, 5'h01);
    inc(1'b1, 1'b0, 16'h0, 16'h0, 16'h65, 16'h32, 16'h0, 5'h03);
    inc(1'b1, 1'b0, 16'h0, 16'h0, 16'h64, 16'h33, 16'h0, 5'h05);
    inc(1'b1, 1'b0, 16'h0, 16'h0, 16'h7FF, 16'h7FF, 16'h0, 5'h07);
    rd(OFF_STAT, 32'h0, RESP_OKAY);
    wr(OFF_CTRL, 32'h0B, RESP_OKAY);
    inc(1'b1, 1'b0, 16'h0, 16'h0, 16'h7FF, 16'h7FF, 16'h0, 5'h01);
    rd(OFF_CNT, 32'h0000002A, RESP_OKAY);
    $display("Test power flow and unknown code done");
    finish_test();
  end
endmodule
